/* shared/dvsr_defines.vh */
// Purpose: Constants for the voltage-scaling regulator control block
// Assumes: 250 MHz core clock
// Notes: Offsets are 3-bit register indices on the serial link
`ifndef DVSR_DEFINES_VH
`define DVSR_DEFINES_VH

// Serial slave address, upper seven bits of the address byte
`define DVSR_SLAVE_ADDR 7'h5B

// Register indices
`define DVSR_REG_CTRL 3'h1
`define DVSR_REG_VCODE_A 3'h2
`define DVSR_REG_VCODE_B 3'h3

// Enable/status field positions
`define DVSR_BIT_THERMAL 6
`define DVSR_BIT_SUPPLY_LOW 5
`define DVSR_BIT_IN_RANGE 4
`define DVSR_BIT_LONG_RAMP 1
`define DVSR_BIT_REG_EN 0

// Values loaded on the enable rising edge
`define DVSR_CTRL_RST 8'h01
`define DVSR_VCODE_A_RST 8'h1E
`define DVSR_VCODE_B_RST 8'h0A

// Voltage code limits and scale
`define DVSR_VCODE_MAX 8'hAA
`define DVSR_VBASE_MV 12'h2BC
`define DVSR_VSTEP_MV 12'h00A

// Switching timing
`define DVSR_CLK_MHZ 250
`define DVSR_FREQ_KHZ 3000
`define DVSR_DUTY_MAX_PCT 80
`define DVSR_MIN_ON_NS 20
// Cycle counts sized to the 7-bit timing counters, so no bits drop:
// period 83 (~3 MHz), max on 66 (80 %), min off 17, min on 5 (20 ns)
`define DVSR_PERIOD_CYC 7'h53
`define DVSR_MAX_ON_CYC 7'h42
`define DVSR_MIN_OFF_CYC 7'h11
`define DVSR_MIN_ON_CYC 7'h05

`endif

/* logic/dvsr_sync.v */
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes: Only the second stage leaves this module
module dvsr_sync #(
    parameter W = 9
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // First stage feeds only the second
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= d_i[g];
                    sync_q <= meta_q;
                end
            end
            assign q_o[g] = sync_q;
        end
    endgenerate

endmodule

/* logic/dvsr_switch_ctrl.v */
// Purpose: Minimum on/off-time switch timing for the buck stage
// Assumes: below_i is already synchronised
// Notes: Period of max-on plus min-off sets the continuous-conduction frequency
`include "dvsr_defines.vh"
module dvsr_switch_ctrl (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Control
    input wire run_i,
    input wire below_i,
    // Gate drive and mode
    output reg hs_on_o,
    output reg ls_on_o,
    output reg cont_o
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_ON = 2'h1;
    localparam [1:0] S_OFF = 2'h2;
    localparam [6:0] MIN_ON = `DVSR_MIN_ON_CYC;
    localparam [6:0] MAX_ON = `DVSR_MAX_ON_CYC;
    localparam [6:0] MIN_OFF = `DVSR_MIN_OFF_CYC;

    reg [1:0] st_q;
    reg [6:0] cnt_q;

    // On/off timing; low side conducts when high side is off while running; both gates off while run_i is low
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= S_IDLE;
            cnt_q <= 7'h00;
            hs_on_o <= 1'b0;
            ls_on_o <= 1'b0;
            cont_o <= 1'b0;
        end else if (!run_i) begin
            st_q <= S_IDLE;
            cnt_q <= 7'h00;
            hs_on_o <= 1'b0;
            ls_on_o <= 1'b0;
            cont_o <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    ls_on_o <= ~below_i;
                    if (below_i) begin
                        st_q <= S_ON;
                        cnt_q <= 7'h01;
                        hs_on_o <= 1'b1;
                    end
                end
                S_ON: begin
                    // Stretch while low, capped at the duty limit
                    if (cnt_q >= MIN_ON && (!below_i || cnt_q >= MAX_ON)) begin
                        st_q <= S_OFF;
                        cnt_q <= 7'h01;
                        hs_on_o <= 1'b0;
                        ls_on_o <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 7'h01;
                    end
                end
                S_OFF: begin
                    if (cnt_q >= MIN_OFF && below_i) begin
                        st_q <= S_ON;
                        cnt_q <= 7'h01;
                        hs_on_o <= 1'b1;
                        ls_on_o <= 1'b0;
                        cont_o <= (cnt_q == MIN_OFF);
                    end else if (cnt_q != 7'h7F) begin
                        cnt_q <= cnt_q + 7'h01;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

/* logic/dvsr_top.v */
// Purpose: Serial register slave and setpoint control for a voltage-scaling buck
// Assumes: All pins asynchronous; 250 MHz core clock oversamples SCL
// Notes: Registers stay zero while enable is low

`include "dvsr_defines.vh"

// Function
// - Acknowledge slave address 1011011 with write 0, read 1.
// - Take register-address byte, decode only its low three bits.
// - Master drives lines except acknowledges and read data, which the device drives.
// - Three 8-bit registers, all readable and writable.
// - Enable low holds every register at zero.
// - Enable rising loads every register with its default.
// - Setpoint is 0.7 V plus 0.01 V times selected code.
// - Highest code 170 gives 2.4 V; each step is 10 mV.
// - Select pin low uses code A, high uses code B.
// - Writing the selected code while enabled moves setpoint at once.
// - Trip drivers at 160 C, hold off until below 140 C.
// - Below threshold starts a cycle with at least minimum on-time.
// - Above threshold keeps high side off at least minimum off-time.
// - Low side conducts when high side is off while running; both gates are off while output is off.
// - Heavy load runs continuous conduction near 3 MHz.
// - High-side duty limited to 80 percent of each period.
// - Status and control bit layout; codes are full bytes.
// - Codes written above 170 behave as 170.
// - Enable bit set turns output on; cleared turns it off.
// - Undervoltage bit follows the lockout circuit.
// - Thermal bit set when thermal shutdown triggers.
module dvsr_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Serial link
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // Control pins
    input wire en_i,
    input wire vsel_i,
    // Analog monitors
    input wire below_thresh_i,
    input wire temp_trip_i,
    input wire temp_clear_i,
    input wire supply_lockout_i,
    input wire in_range_i,
    // Power stage
    output wire hs_gate_o,
    output wire ls_gate_o,
    output wire continuous_conduction_o,
    output wire output_on_o,
    output reg long_ramp_enable_o,
    output reg thermal_trip_flag_o,
    // Setpoint
    output reg [7:0] setpoint_code_o,
    output reg [11:0] setpoint_mv_o
);

    // Transfer states
    localparam [3:0] T_IDLE = 4'h0;
    localparam [3:0] T_ADDR = 4'h1;
    localparam [3:0] T_ACKA = 4'h2;
    localparam [3:0] T_REG = 4'h3;
    localparam [3:0] T_ACKR = 4'h4;
    localparam [3:0] T_WDAT = 4'h5;
    localparam [3:0] T_ACKW = 4'h6;
    localparam [3:0] T_RDAT = 4'h7;
    localparam [3:0] T_RACK = 4'h8;

    wire [8:0] sync_w;
    wire scl_s;
    wire sda_s;
    wire en_s;
    wire vsel_s;
    wire below_s;
    wire hot_s;
    wire cool_s;
    wire lockout_s;
    wire in_range_s;

    reg scl_prev_q;
    reg sda_prev_q;
    reg en_prev_q;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    reg [3:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg rw_q;
    reg ack_ok_q;
    reg [2:0] ptr_q;
    reg wr_stb_q;
    reg [7:0] wr_data_q;

    reg long_ramp_q;
    reg reg_en_q;
    reg [7:0] vcode_a_q;
    reg [7:0] vcode_b_q;
    reg thermal_q;
    reg [7:0] status_w;
    reg [7:0] rd_data;
    wire [7:0] sel_code;
    wire run;

    // Limit a written code to the top step
    function [7:0] clamp_code;
        input [7:0] v;
        begin
            if (v > `DVSR_VCODE_MAX) begin
                clamp_code = `DVSR_VCODE_MAX;
            end else begin
                clamp_code = v;
            end
        end
    endfunction

    // Every pin passes two flops before use
    dvsr_sync #(
        .W(9)
    ) u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i({in_range_i, supply_lockout_i, temp_clear_i, temp_trip_i,
              below_thresh_i, vsel_i, en_i, sda_i, scl_i}),
        .q_o(sync_w)
    );

    assign scl_s = sync_w[0];
    assign sda_s = sync_w[1];
    assign en_s = sync_w[2];
    assign vsel_s = sync_w[3];
    assign below_s = sync_w[4];
    assign hot_s = sync_w[5];
    assign cool_s = sync_w[6];
    assign lockout_s = sync_w[7];
    assign in_range_s = sync_w[8];

    // Previous samples for edge finding
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_prev_q <= 1'b0; // Matches synchroniser reset, no false edge
            sda_prev_q <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
            en_prev_q <= en_s;
        end
    end

    // Start and stop are SDA edges with SCL high
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // Read view of status and control
    always @* begin
        status_w = 8'h00;
        status_w[`DVSR_BIT_THERMAL] = thermal_q & en_s;
        status_w[`DVSR_BIT_SUPPLY_LOW] = lockout_s & en_s;
        status_w[`DVSR_BIT_IN_RANGE] = in_range_s & en_s;
        status_w[`DVSR_BIT_LONG_RAMP] = long_ramp_q;
        status_w[`DVSR_BIT_REG_EN] = reg_en_q;
    end

    // Read mux; unmapped indices answer zero
    always @* begin
        case (ptr_q)
            `DVSR_REG_CTRL: rd_data = status_w;
            `DVSR_REG_VCODE_A: rd_data = vcode_a_q;
            `DVSR_REG_VCODE_B: rd_data = vcode_b_q;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial slave: sample on SCL rise, change SDA on SCL fall.
    // SDA is only ever pulled low, so sda_o stays zero.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= T_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            rw_q <= 1'b0;
            ack_ok_q <= 1'b0;
            ptr_q <= 3'h0;
            wr_stb_q <= 1'b0;
            wr_data_q <= 8'h00;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            sda_o <= 1'b0;
            if (start_det) begin
                // Repeated start also lands here
                st_q <= T_ADDR;
                bit_q <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_det) begin
                st_q <= T_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                case (st_q)
                    T_ADDR, T_REG, T_WDAT: begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end
                    T_RACK: begin
                        ack_ok_q <= ~sda_s;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (st_q)
                    T_ADDR: begin
                        if (bit_q == 4'h8) begin
                            if (sh_q[7:1] == `DVSR_SLAVE_ADDR) begin
                                rw_q <= sh_q[0];
                                sda_oe_o <= 1'b1;
                                st_q <= T_ACKA;
                            end else begin
                                st_q <= T_IDLE;
                            end
                        end
                    end
                    T_REG: begin
                        if (bit_q == 4'h8) begin
                            ptr_q <= sh_q[2:0];
                            sda_oe_o <= 1'b1;
                            st_q <= T_ACKR;
                        end
                    end
                    T_WDAT: begin
                        if (bit_q == 4'h8) begin
                            wr_stb_q <= 1'b1;
                            wr_data_q <= sh_q;
                            sda_oe_o <= 1'b1;
                            st_q <= T_ACKW;
                        end
                    end
                    T_ACKA: begin
                        bit_q <= 4'h0;
                        if (rw_q) begin
                            sh_q <= rd_data;
                            sda_oe_o <= ~rd_data[7];
                            st_q <= T_RDAT;
                        end else begin
                            sda_oe_o <= 1'b0;
                            st_q <= T_REG;
                        end
                    end
                    T_ACKR, T_ACKW: begin
                        // Further bytes rewrite the same register
                        bit_q <= 4'h0;
                        sda_oe_o <= 1'b0;
                        st_q <= T_WDAT;
                    end
                    T_RDAT: begin
                        if (bit_q == 4'h7) begin
                            sda_oe_o <= 1'b0;
                            st_q <= T_RACK;
                        end else begin
                            sda_oe_o <= ~sh_q[6];
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    T_RACK: begin
                        // Master ack repeats the same register
                        if (ack_ok_q) begin
                            sh_q <= rd_data;
                            sda_oe_o <= ~rd_data[7];
                            bit_q <= 4'h0;
                            st_q <= T_RDAT;
                        end else begin
                            st_q <= T_IDLE;
                        end
                    end
                    default: begin
                        st_q <= T_IDLE;
                    end
                endcase
            end
        end
    end

    // Register file; enable pin overrides any write
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            long_ramp_q <= 1'b0;
            reg_en_q <= 1'b0;
            vcode_a_q <= 8'h00;
            vcode_b_q <= 8'h00;
        end else if (!en_s) begin
            long_ramp_q <= 1'b0;
            reg_en_q <= 1'b0;
            vcode_a_q <= 8'h00;
            vcode_b_q <= 8'h00;
        end else if (!en_prev_q) begin
            long_ramp_q <= |(`DVSR_CTRL_RST & (8'h01 << `DVSR_BIT_LONG_RAMP));
            reg_en_q <= |(`DVSR_CTRL_RST & (8'h01 << `DVSR_BIT_REG_EN));
            vcode_a_q <= `DVSR_VCODE_A_RST;
            vcode_b_q <= `DVSR_VCODE_B_RST;
        end else if (wr_stb_q) begin
            case (ptr_q)
                `DVSR_REG_CTRL: begin
                    // Status bits are hardware owned
                    long_ramp_q <= wr_data_q[`DVSR_BIT_LONG_RAMP];
                    reg_en_q <= wr_data_q[`DVSR_BIT_REG_EN];
                end
                `DVSR_REG_VCODE_A: vcode_a_q <= clamp_code(wr_data_q);
                `DVSR_REG_VCODE_B: vcode_b_q <= clamp_code(wr_data_q);
                default: begin
                end
            endcase
        end
    end

    // Hysteretic thermal latch; trip beats clear
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            thermal_q <= 1'b0;
        end else if (hot_s) begin
            thermal_q <= 1'b1;
        end else if (cool_s) begin
            thermal_q <= 1'b0;
        end
    end

    // Setpoint follows the selected code a cycle later
    assign sel_code = vsel_s ? vcode_b_q : vcode_a_q;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            setpoint_code_o <= 8'h00;
            setpoint_mv_o <= 12'h000;
            long_ramp_enable_o <= 1'b0;
            thermal_trip_flag_o <= 1'b0;
        end else begin
            setpoint_code_o <= sel_code;
            // Max 700 + 10 * 170 = 2400 fits twelve bits
            setpoint_mv_o <= `DVSR_VBASE_MV + {4'h0, sel_code} * `DVSR_VSTEP_MV;
            long_ramp_enable_o <= long_ramp_q;
            thermal_trip_flag_o <= thermal_q;
        end
    end

    // Drivers run only when enabled and no protection is active
    assign run = en_s & reg_en_q & ~thermal_q & ~lockout_s;
    assign output_on_o = run;

    dvsr_switch_ctrl u_sw (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(run),
        .below_i(below_s),
        .hs_on_o(hs_gate_o),
        .ls_on_o(ls_gate_o),
        .cont_o(continuous_conduction_o)
    );

endmodule

/* verif/dvsr_i2c_master.sv */
// Purpose: Serial link master standing in for the host processor
// Assumes: Open-drain data wire resolved by the bench with a pull-up
// Notes: slow_i stretches the bus-free gap after each stop; bit timing stays fixed
module dvsr_i2c_master (
    // Clock
    input wire clk_i,
    // Link
    input wire sda_i,
    input wire slow_i,
    output logic scl_o,
    output logic sda_low_o,
    // Read result
    output logic rd_valid_o,
    output logic [7:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock line stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o = 8'h00;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start_c();
        sda_low_o <= 1'b0;
        wt(5);
        scl_o <= 1'b1;
        wt(5);
        sda_low_o <= 1'b1;
        wt(5);
        scl_o <= 1'b0;
        wt(5);
    endtask
    task automatic stop_c();
        sda_low_o <= 1'b1;
        wt(5);
        scl_o <= 1'b1;
        wt(5);
        sda_low_o <= 1'b0;
        wt(slow_i ? 40 : 5);
    endtask
    // Data moves only while clock is low, sampled late in the high phase
    task automatic bit_c(input logic b, output logic s);
        sda_low_o <= !b;
        wt(5);
        scl_o <= 1'b1;
        wt(10);
        s = sda_i;
        scl_o <= 1'b0;
        wt(5);
    endtask
    // Line released in the ninth bit so the device can acknowledge
    task automatic byte_c(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_c(d[i], s);
        bit_c(1'b1, s);
        ack = !s;
    endtask
    task automatic wr(input logic [7:0] a, r, d, output logic ok);
        logic k0, k1, k2;
        start_c();
        byte_c(a, k0);
        byte_c(r, k1);
        byte_c(d, k2);
        stop_c();
        ok = k0 & k1 & k2;
    endtask
    // Address-only write, repeated start, one byte read then refused
    task automatic rd(input logic [7:0] r, output logic ok);
        logic k0, k1, k2, s;
        logic [7:0] d;
        start_c();
        byte_c(8'hB6, k0);
        byte_c(r, k1);
        start_c();
        byte_c(8'hB7, k2);
        for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
        bit_c(1'b1, s);
        stop_c();
        ok = k0 & k1 & k2;
        rd_data_o <= d;
        rd_valid_o <= 1'b1;
        @(posedge clk_i);
        rd_valid_o <= 1'b0;
    endtask
endmodule

/* verif/dvsr_top_asserts.sv */
// Purpose: Timing checks on the regulator control top
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Counters stand in for long repetitions
module dvsr_top_chk (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Watched pins
    input wire scl_i,
    input wire temp_clear_i,
    input wire sda_oe_o,
    input wire hs_gate_o,
    input wire ls_gate_o,
    input wire output_on_o,
    input wire thermal_trip_flag_o,
    input wire [7:0] setpoint_code_o,
    input wire [11:0] setpoint_mv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] on_q;
    logic [7:0] off_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Gate run lengths; off count starts saturated so the first pulse passes
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            on_q <= 8'h00;
            off_q <= 8'hFF;
        end else begin
            on_q <= hs_gate_o ? on_q + 8'h01 : 8'h00;
            off_q <= hs_gate_o ? 8'h00 : (off_q == 8'hFF ? off_q : off_q + 8'h01);
        end
    end
    chk_sda_low_phase: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line changed while clock high");
    chk_gate_overlap: assert property (hs_gate_o |-> !ls_gate_o)
        else $error("both gates on");
    chk_min_on: assert property ($rose(hs_gate_o) |-> hs_gate_o [*5])
        else $error("high side pulse shorter than minimum");
    chk_duty_cap: assert property (hs_gate_o |-> on_q <= 8'h41)
        else $error("high side on beyond duty limit");
    chk_min_off: assert property ($rose(hs_gate_o) |-> off_q >= 8'h11)
        else $error("high side off shorter than minimum");
    chk_code_cap: assert property (setpoint_code_o <= 8'hAA)
        else $error("setpoint code above ceiling");
    chk_mv_scale: assert property (($changed(setpoint_code_o) && setpoint_code_o != 8'h00)
        |=> setpoint_mv_o == 12'h2BC + 12'h00A * $past(setpoint_code_o))
        else $error("setpoint millivolts wrong");
    chk_thermal_hold: assert property (thermal_trip_flag_o && !temp_clear_i
        |=> thermal_trip_flag_o)
        else $error("thermal trip dropped before clear");
    chk_thermal_off: assert property (thermal_trip_flag_o && $past(thermal_trip_flag_o)
        |-> !$past(output_on_o))
        else $error("output on during thermal trip");
endmodule
bind dvsr_top dvsr_top_chk u_chk (.clk_i, .rst_b_i, .scl_i, .temp_clear_i, .sda_oe_o,
    .hs_gate_o, .ls_gate_o, .output_on_o, .thermal_trip_flag_o, .setpoint_code_o,
    .setpoint_mv_o);

/* verif/dvs_i2c_register_control_tb.sv */
// Purpose: Self-checking bench for the regulator control top
// Assumes: 250 MHz clock, serial link at 80 ns per bit
// Notes: Read results are matched against a queue of noted values
module dvs_i2c_register_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b0, vsel = 1'b0, below = 1'b0;
    logic trip = 1'b0, clr = 1'b1, lockout = 1'b0, in_range = 1'b0, slow = 1'b0;
    wire scl, sda_low, rd_valid, sda_o, sda_oe, hs, ls, cont, out_on, ramp, tflag;
    wire [7:0] rd_data, code;
    wire [11:0] mv;
    wire sda = !(sda_low || (sda_oe && !sda_o));
    logic [7:0] exp_q[$];
    logic [7:0] cur [2];
    int fail_count = 0;
    int num_checks = 0;
    dvsr_top dut (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .en_i(en), .vsel_i(vsel), .below_thresh_i(below),
        .temp_trip_i(trip), .temp_clear_i(clr), .supply_lockout_i(lockout),
        .in_range_i(in_range), .hs_gate_o(hs), .ls_gate_o(ls), .continuous_conduction_o(cont),
        .output_on_o(out_on), .long_ramp_enable_o(ramp), .thermal_trip_flag_o(tflag),
        .setpoint_code_o(code), .setpoint_mv_o(mv));
    dvsr_i2c_master m (.clk_i(clk), .sda_i(sda), .slow_i(slow), .scl_o(scl),
        .sda_low_o(sda_low), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic ok;
        m.wr(8'hB6, r, d, ok);
        chk(16'(ok), 16'h0001);
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] e);
        logic ok;
        exp_q.push_back(e);
        m.rd(r, ok);
        chk(16'(ok), 16'h0001);
    endtask
    task automatic chk_sp();
        chk(16'(code), 16'(cur[vsel]));
        chk(16'(mv), 16'h02BC + 16'h000A * cur[vsel]);
    endtask
    // Bounded wait for the next high-side rising edge
    task automatic wait_rise(output int n);
        n = 0;
        while (hs !== 1'b0 && n < 300) begin cyc(1); n++; end
        while (hs !== 1'b1 && n < 300) begin cyc(1); n++; end
        if (n >= 300) begin
            fail_count++;
            results();
        end
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    // Watchdog: a hang counts as a mismatch
    initial begin
        cyc(100000);
        fail_count++;
        results();
    end
    // Oldest note is taken off the queue whenever a read completes
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(16'(rd_data), 16'hFFFF);
            else chk(16'(rd_data), 16'(exp_q.pop_front()));
        end
    end
    initial begin
        logic [7:0] v;
        logic [7:0] e;
        logic [2:0] idx;
        logic ok;
        int per;
        void'($urandom(97880));
        cur[0] = 8'h1E;
        cur[1] = 8'h0A;
        cyc(12);
        rst_b <= 1'b1;
        cyc(4);
        wr(8'h02, 8'h55);
        rd(8'h02, 8'h00);
        en <= 1'b1;
        cyc(8);
        rd(8'h01, 8'h01);
        rd(8'h02, 8'h1E);
        rd(8'h03, 8'h0A);
        chk_sp();
        // Codes with boundary values, random upper address bits and select
        for (int i = 0; i < 12; i++) begin
            idx = 3'h2 + 3'(i % 2);
            v = (i == 0) ? 8'hAA : (i == 1) ? 8'hAB : (i == 3) ? 8'hFF : 8'($urandom);
            e = (v > 8'hAA) ? 8'hAA : v;
            slow <= i[1];
            vsel <= 1'($urandom);
            wr({5'($urandom), idx}, v);
            cur[idx[0]] = e;
            cyc(4);
            chk_sp();
            rd({5'($urandom), idx}, e);
        end
        for (int r = 0; r < 8; r++) begin
            if (r == 0 || r > 3) begin
                wr(8'(r), 8'h5A);
                rd(8'(r), 8'h00);
            end
        end
        m.wr(8'hB4, 8'h02, 8'h11, ok);
        chk(16'(ok), 16'h0000);
        rd(8'h02, cur[0]);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h03);
        chk(16'(ramp), 16'h0001);
        chk(16'(out_on), 16'h0001);
        wr(8'h01, 8'h00);
        cyc(4);
        chk(16'(out_on), 16'h0000);
        wr(8'h01, 8'h01);
        lockout <= 1'b1;
        in_range <= 1'b1;
        cyc(6);
        chk(16'(out_on), 16'h0000);
        rd(8'h01, 8'h31);
        lockout <= 1'b0;
        cyc(6);
        rd(8'h01, 8'h11);
        clr <= 1'b0;
        trip <= 1'b1;
        cyc(3);
        trip <= 1'b0;
        cyc(6);
        chk(16'(out_on), 16'h0000);
        rd(8'h01, 8'h51);
        chk(16'(tflag), 16'h0001);
        clr <= 1'b1;
        in_range <= 1'b0;
        cyc(6);
        chk(16'(tflag), 16'h0000);
        chk(16'(out_on), 16'h0001);
        // Light load: comparator toggles at random
        for (int i = 0; i < 800; i++) begin
            below <= ($urandom % 4) != 0;
            cyc(1);
        end
        below <= 1'b1;
        cyc(200);
        wait_rise(per);
        wait_rise(per);
        chk(16'(per), 16'h0053);
        chk(16'(cont), 16'h0001);
        chk(16'(ls), 16'(!hs));
        // Let the last pulse finish before disabling, so min on-time holds
        below <= 1'b0;
        cyc(80);
        en <= 1'b0;
        cyc(8);
        chk(16'(out_on), 16'h0000);
        rd(8'h02, 8'h00);
        en <= 1'b1;
        cyc(8);
        rd(8'h03, 8'h0A);
        cyc(20);
        chk(16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule
